// ---- verilog/tsr_pkg.sv ----
// Package for the serial temperature sensor register block.
// Holds word layouts, mode codes and reset values shared by all design files.
package tsr_pkg;

  // Word geometry of one transaction.
  localparam int TSR_WORD_BITS     = 16;
  localparam int TSR_TEMP_BITS     = 11;
  localparam int TSR_CFG_BITS      = 8;
  localparam int TSR_DRIVEN_BITS   = 14;
  localparam int TSR_FRAME_CLOCKS  = 32;
  localparam int TSR_TEMP_LSB_POS  = 5;

  // Bit counter width, enough to count a full frame.
  localparam int TSR_CNT_W         = 6;

  // Configuration codes, low byte only.
  localparam logic [7:0] TSR_CFG_SHUTDOWN = 8'hFF;
  localparam logic [7:0] TSR_CFG_CONVERT  = 8'h00;

  // Fill bits below the temperature field.
  localparam logic [2:0] TSR_TEMP_FILL    = 3'h7;
  localparam logic [2:0] TSR_ID_FILL      = 3'h0;

  // Identity field in bits 15..5; the value is arbitrary.
  localparam logic [10:0] TSR_IDENT_CODE  = 11'h2A5;

  // Value after reset of the temperature sample.
  localparam logic [10:0] TSR_TEMP_RESET  = 11'h000;

  // Operating modes.
  typedef enum logic {
    TSR_MODE_CONVERT,
    TSR_MODE_SHUTDOWN
  } tsr_mode_t;

  // Word handed from the system domain to the link domain.
  typedef struct packed {
    logic [10:0] value;
    logic        shutdown;
  } tsr_snap_t;

endpackage : tsr_pkg

// ---- verilog/tsr_sync.sv ----
// Three-stage synchroniser for a level entering the system clock domain.
// Assumes the input is asynchronous to i_clock; output changes once stages two and three agree.
`timescale 1ns/10ps
module tsr_sync
  import tsr_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             i_clock,
  input  wire logic             i_resetn,
  // Level in and filtered level out.
  input  wire logic [WIDTH-1:0] i_level,
  output logic      [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // The first stage feeds only the second, to keep metastability contained.
  // Stages reset to the idle level of an active-low select, so that the
  // release of reset never shows a false rising edge downstream.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      stage1  <= '1;
      stage2  <= '1;
      stage3  <= '1;
      o_level <= '1;
    end else begin
      stage1 <= i_level;
      stage2 <= stage1;
      stage3 <= stage2;
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          o_level[i] <= stage3[i];
        end
      end
    end
  end

endmodule : tsr_sync

// ---- verilog/tsr_shifter.sv ----
// Link-side serial engine clocked by the serial bus clock.
// Assumes chip select is active low and asynchronously resets the falling-edge count and frame flag between frames.
`timescale 1ns/10ps
module tsr_shifter
  import tsr_pkg::*;
(
  // Link clock and frame select.
  input  wire logic       i_serial_bus_clock,
  input  wire logic       i_csn,
  // Word to send, already stable for the whole frame.
  input  wire tsr_snap_t  i_snap,
  // Data pin pieces.
  input  wire logic       i_sio,
  output logic            o_sio,
  output logic            o_sio_oe,
  // Received configuration byte and count of rising edges.
  output logic [7:0]      o_cfg_shift,
  output logic [TSR_CNT_W-1:0] o_rise_count
);

  logic [15:0] tx_word;
  logic [TSR_CNT_W-1:0] fall_count;
  logic                 frame_live;

  // Outgoing word: field, three fill bits, two released bits.
  always_comb begin
    tx_word = {i_snap.value,
               i_snap.shutdown ? TSR_ID_FILL : TSR_TEMP_FILL, 2'h0};
  end

  // Falling edges count bits already presented; the first bit shows at select.
  always_ff @(negedge i_serial_bus_clock or posedge i_csn) begin
    if (i_csn) begin
      fall_count <= '0;
    end else if (fall_count < TSR_CNT_W'(TSR_FRAME_CLOCKS)) begin
      fall_count <= fall_count + TSR_CNT_W'(1);
    end
  end

  // Drive on falling edges, release after 14 bits and outside the read phase.
  always_comb begin
    o_sio_oe = !i_csn && (fall_count < TSR_CNT_W'(TSR_DRIVEN_BITS));
    o_sio    = o_sio_oe ? tx_word[4'(15 - fall_count)] : 1'b0;
  end

  // Marks that the frame has had its first rising edge; select high clears it.
  always_ff @(posedge i_serial_bus_clock or posedge i_csn) begin
    if (i_csn) begin
      frame_live <= 1'b0;
    end else begin
      frame_live <= 1'b1;
    end
  end

  // Rising edges of the frame. Select going high must not clear this count,
  // since the system side reads it only after deselect; the first rising
  // edge of the next frame restarts it instead.
  always_ff @(posedge i_serial_bus_clock) begin
    if (!frame_live) begin
      o_rise_count <= TSR_CNT_W'(1);
    end else if (o_rise_count < TSR_CNT_W'(TSR_FRAME_CLOCKS)) begin
      o_rise_count <= o_rise_count + TSR_CNT_W'(1);
    end
  end

  // The shift register survives select going high so the system side can read it.
  // Only rising edges 17 and later of a live frame are taken into it.
  always_ff @(posedge i_serial_bus_clock) begin
    if (!i_csn && frame_live && o_rise_count >= TSR_CNT_W'(TSR_WORD_BITS)) begin
      o_cfg_shift <= {o_cfg_shift[6:0], i_sio};
    end
  end

endmodule : tsr_shifter

// ---- verilog/tsr_top.sv ----
// Top of the serial temperature sensor register block.
// Assumes a host drives chip select and the serial clock; i_clock runs free at 125 MHz.
// Summary of operation
// - Low byte all ones enters shutdown.
// - Low byte all zeros enters conversion mode.
// - Temperature word bits 4..2 driven high.
// - Bits 15..5 hold two's complement temperature.
// - Identity word bits 4..2 driven low.
// - Shutdown reads return the identity word.
// - Output changes falling, input sampled rising.
// - Frame: 16 read clocks, 16 write clocks.
// - Release data line after fourteen bits.
// - Decode last eight bits before deselect.
`timescale 1ns/10ps
module tsr_top
  import tsr_pkg::*;
(
  // System clock and reset.
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  // Temperature sample from the converter, system domain.
  input  wire logic [10:0] i_temp_value,
  input  wire logic        i_temp_valid,
  // Serial link.
  input  wire logic        i_serial_bus_clock,
  input  wire logic        i_csn,
  input  wire logic        i_sio,
  output logic             o_sio,
  output logic             o_sio_oe,
  // Status.
  output logic             o_shutdown
);

  tsr_mode_t   mode;
  logic [10:0] temp_value;
  tsr_snap_t   snap;
  logic        csn_sys;
  logic        csn_sys_d;
  logic [7:0]  cfg_shift;
  logic [TSR_CNT_W-1:0] rise_count;
  logic        link_sio;
  logic        link_oe;

  // Latest converter result, held for the next frame.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      temp_value <= TSR_TEMP_RESET;
    end else if (i_temp_valid) begin
      temp_value <= i_temp_value;
    end
  end

  // Snapshot changes only while deselected, so the link side sees a stable word.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      snap <= '{value: TSR_TEMP_RESET, shutdown: 1'b0};
    end else if (csn_sys && csn_sys_d) begin
      snap.shutdown <= (mode == TSR_MODE_SHUTDOWN);
      snap.value    <= (mode == TSR_MODE_SHUTDOWN) ? TSR_IDENT_CODE : temp_value;
    end
  end

  // Chip select crosses into the system domain as a level.
  tsr_sync #(.WIDTH(1)) u_csn_sync (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_level  (i_csn),
    .o_level  (csn_sys)
  );

  // Edge history of the synchronised select.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      csn_sys_d <= 1'b1;
    end else begin
      csn_sys_d <= csn_sys;
    end
  end

  // On deselect the link clock is still, so the shift register is stable to read.
  // Fewer than eight write bits leave the mode unchanged; other codes are ignored
  // here, since a host is not allowed to send them.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      mode <= TSR_MODE_CONVERT;
    end else if (csn_sys && !csn_sys_d &&
                 rise_count >= TSR_CNT_W'(TSR_WORD_BITS + TSR_CFG_BITS)) begin
      case (cfg_shift)
        TSR_CFG_SHUTDOWN: mode <= TSR_MODE_SHUTDOWN;
        TSR_CFG_CONVERT:  mode <= TSR_MODE_CONVERT;
        default:          mode <= mode;
      endcase
    end
  end

  // Serial engine on the link clock.
  tsr_shifter u_shifter (
    .i_serial_bus_clock (i_serial_bus_clock),
    .i_csn              (i_csn),
    .i_snap             (snap),
    .i_sio              (i_sio),
    .o_sio              (link_sio),
    .o_sio_oe           (link_oe),
    .o_cfg_shift        (cfg_shift),
    .o_rise_count       (rise_count)
  );

  // Pin outputs are combinational from the link engine; a flop here would be
  // on a different clock, so these two are the one exception to registered outputs.
  always_comb begin
    o_sio    = link_sio;
    o_sio_oe = link_oe;
  end

  // Mode status.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_shutdown <= 1'b0;
    end else begin
      o_shutdown <= (mode == TSR_MODE_SHUTDOWN);
    end
  end

endmodule : tsr_top

// ---- bench/tsr_checker.sv ----
// Checker for the sensor block top, bound to every tsr_top.
// Assumes the serial clock idles low and chip select frames it.
`timescale 1ns/10ps
module tsr_checker
  import tsr_pkg::*;
(
  // System side.
  input wire logic        i_clock,
  input wire logic        i_resetn,
  input wire logic [10:0] i_temp_value,
  input wire logic        i_temp_valid,
  // Link side.
  input wire logic        i_serial_bus_clock,
  input wire logic        i_csn,
  input wire logic        i_sio,
  input wire logic        o_sio,
  input wire logic        o_sio_oe,
  input wire logic        o_shutdown
);
  wire         sc = i_serial_bus_clock;
  logic [5:0]  n;
  logic [5:0]  r;
  logic [7:0]  sh;
  logic [10:0] tv;
  logic        ok;
  // Falling edges seen in the frame; chip select high clears it.
  always_ff @(negedge sc or posedge i_csn) begin
    if (i_csn) n <= 6'h00;
    else n <= n + 6'h01;
  end
  // Rising edges seen, and the bits taken on them.
  always_ff @(posedge sc or posedge i_csn) begin
    if (i_csn) r <= 6'h00;
    else r <= r + 6'h01;
  end
  always_ff @(posedge sc) sh <= {sh[6:0], i_sio};
  // A write counts only with eight bits past the read half.
  always_ff @(posedge i_clock) begin
    if (!i_csn) ok <= (r >= 6'h18);
  end
  // Last temperature loaded, the value a frame must carry.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) tv <= TSR_TEMP_RESET;
    else if (i_temp_valid) tv <= i_temp_value;
  end
  property p_oe; @(posedge sc) disable iff (i_csn) o_sio_oe == (n < 6'h0E); endproperty
  a_oe: assert property (p_oe) else $error("enable wrong");
  property p_fill1; @(posedge sc) disable iff (i_csn)
    n inside {[6'h0B:6'h0D]} && !o_shutdown |-> o_sio; endproperty
  a_fill1: assert property (p_fill1) else $error("fill high");
  property p_fill0; @(posedge sc) disable iff (i_csn)
    n inside {[6'h0B:6'h0D]} && o_shutdown |-> !o_sio; endproperty
  a_fill0: assert property (p_fill0) else $error("fill low");
  property p_temp; @(posedge sc) disable iff (i_csn)
    n < 6'h0B && !o_shutdown |-> o_sio == tv[6'h0A - n]; endproperty
  a_temp: assert property (p_temp) else $error("temp bit");
  property p_ident; @(posedge sc) disable iff (i_csn)
    n < 6'h0B && o_shutdown |-> o_sio == TSR_IDENT_CODE[6'h0A - n]; endproperty
  a_ident: assert property (p_ident) else $error("ident bit");
  property p_edge; @(posedge i_clock) disable iff (!i_resetn)
    !i_csn && sc && $past(sc) && $past(o_sio_oe) |-> $stable(o_sio); endproperty
  a_edge: assert property (p_edge) else $error("data moved");
  property p_shut; @(posedge i_clock) disable iff (!i_resetn)
    $rose(i_csn) && ok && sh == 8'hFF |-> ##[1:8] o_shutdown; endproperty
  a_shut: assert property (p_shut) else $error("no shutdown");
  property p_conv; @(posedge i_clock) disable iff (!i_resetn)
    $rose(i_csn) && ok && sh == 8'h00 |-> ##[1:8] !o_shutdown; endproperty
  a_conv: assert property (p_conv) else $error("no convert");
endmodule : tsr_checker
bind tsr_top tsr_checker i_chk (.*);

// ---- bench/tsr_host.sv ----
// Host model: frames the link and owns the shared data line.
// Assumes the device enable says when the device drives.
`timescale 1ns/10ps
module tsr_host (
  // Device pin pieces.
  input  wire logic i_dev,
  input  wire logic i_dev_oe,
  // Host lines.
  output logic      o_csn = 1'b0,
  output logic      o_sclk = 1'b0,
  output logic      o_line
);
  logic hd = 1'b0;
  logic hv = 1'b0;
  logic tg = 1'b0;
  // Select starts low for one step so every select-cleared flop sees a real edge.
  initial #1 o_csn = 1'b1;
  // A free line toggles so a stale bit can never read as good.
  assign o_line = i_dev_oe ? i_dev : (hd ? hv : tg);
  // One frame: 16 read clocks, then nw write clocks, MSB first.
  task xfer(input logic [15:0] wr, input int nw, output logic [15:0] rd);
    int i;
    rd = 16'h0000;
    #3 o_csn = 1'b0;
    #101;
    for (i = 0; i < 16 + nw; i++) begin
      o_sclk = 1'b1;
      if (i < 16) rd = {rd[14:0], o_line};
      #16 o_sclk = 1'b0;
      tg = ~tg;
      hd = (i >= 15) && (nw > 0);
      if (i >= 15 && i < 15 + nw) hv = wr[30 - i];
      #16;
    end
    #30 o_csn = 1'b1;
    hd = 1'b0;
  endtask : xfer
endmodule : tsr_host

// ---- bench/tsr_top_test.sv ----
// Bench for the sensor block: frames through the host model.
// Assumes the checker is bound to the top by its own file.
`timescale 1ns/10ps
module tsr_top_test
  import tsr_pkg::*;
();
  logic        i_clock;
  logic        i_resetn = 1'b0;
  logic        i_temp_valid = 1'b0;
  logic [10:0] i_temp_value = 11'h000;
  logic [15:0] rd;
  wire         csn, sclk, line, o_sio, o_sio_oe, o_shutdown;
  int          err_count = 0;
  int          cmp_count = 0;
  tsr_top i_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_temp_value(i_temp_value),
    .i_temp_valid(i_temp_valid), .i_serial_bus_clock(sclk), .i_csn(csn), .i_sio(line),
    .o_sio(o_sio), .o_sio_oe(o_sio_oe), .o_shutdown(o_shutdown));
  tsr_host i_host (.i_dev(o_sio), .i_dev_oe(o_sio_oe), .o_csn(csn), .o_sclk(sclk),
    .o_line(line));
  // System clock, 8 ns.
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // The gap after a frame lets the mode settle before it is read.
  task xf(input logic [15:0] wr, input int nw);
    i_host.xfer(wr, nw, rd);
    repeat (12) @(posedge i_clock);
    #1;
  endtask : xf
  task ld(input logic [10:0] v);
    @(posedge i_clock) #1 i_temp_value = v;
    i_temp_valid = 1'b1;
    @(posedge i_clock) #1 i_temp_valid = 1'b0;
    repeat (8) @(posedge i_clock);
  endtask : ld
  task t_temp;
    logic [10:0] tab [4];
    tab = '{11'h258, 11'h7FF, 11'h400, 11'h3FF};
    xf(16'h0000, 16);
    chk({rd[15:2], 2'h0}, 16'h001C);
    foreach (tab[k]) begin
      ld(tab[k]);
      xf(16'h0000, 16);
      chk({rd[15:2], 2'h0}, {tab[k], 3'h7, 2'h0});
    end
  endtask : t_temp
  task t_shut;
    xf(16'hA5FF, 16);
    chk(16'(o_shutdown), 16'h0001);
    xf(16'hFF00, 16);
    chk({rd[15:2], 2'h0}, {TSR_IDENT_CODE, 5'h00});
    chk(16'(o_shutdown), 16'h0000);
  endtask : t_shut
  // Short write, then a read-only frame that must not change the mode.
  task t_part;
    xf(16'hFF00, 8);
    chk(16'(o_shutdown), 16'h0001);
    xf(16'h0000, 0);
    chk({rd[15:2], 2'h0}, {TSR_IDENT_CODE, 5'h00});
    chk(16'(o_shutdown), 16'h0001);
    @(posedge i_clock) #1 i_resetn = 1'b0;
    repeat (4) @(posedge i_clock);
    #1 i_resetn = 1'b1;
    repeat (8) @(posedge i_clock);
    #1;
    chk(16'(o_shutdown), 16'h0000);
    xf(16'h0000, 16);
    chk({rd[15:2], 2'h0}, 16'h001C);
  endtask : t_part
  task print_verdict;
    $display("Errors %0d, checks %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  // Reset is held two edges; every i_clock flop of the design resets in one.
  initial begin
    repeat (2) @(posedge i_clock);
    #1 i_resetn = 1'b1;
    repeat (8) @(posedge i_clock);
    t_temp;
    t_shut;
    t_part;
    print_verdict;
  end
  initial begin
    #100000;
    err_count++;
    print_verdict;
  end
endmodule : tsr_top_test
